// ===== verilog/ris_map.svh
`ifndef RIS_MAP_SVH
`define RIS_MAP_SVH
// ==========================================================
// Register offsets
`define RIS_ADDR_FLAGS      5'h0C
`define RIS_ADDR_ENABLES    5'h0D
`define RIS_ADDR_COL_LOW    5'h0E
`define RIS_ADDR_STRENGTH   5'h0F
// ==========================================================
// Field positions
`define RIS_BIT_TX          7
`define RIS_BIT_RX_START    6
`define RIS_BIT_FIFO        5
`define RIS_BIT_CRC         4
`define RIS_BIT_PARITY      3
`define RIS_BIT_FRAMING     2
`define RIS_BIT_COLLISION   1
`define RIS_BIT_NO_RESP     0
`define RIS_BIT_OSC_OK      6
`define RIS_BIT_NO_RX_CRC   7
// ==========================================================
// Reset values
`define RIS_FLAGS_RESET     8'h00
`define RIS_ENABLES_RESET   6'h3E
`define RIS_COL_RESET       10'h000
`define RIS_STRENGTH_RESET  3'h0
// ==========================================================
// Timing
`define RIS_OSC_SETTLE_NS   200000
`define RIS_CLK_PERIOD_NS   20
`define RIS_OSC_SETTLE_CYC  (`RIS_OSC_SETTLE_NS / `RIS_CLK_PERIOD_NS)
`endif

// ===== verilog/ris_pkg.sv
package ris_pkg;
  typedef enum logic [1:0] {
    RIS_IDLE,
    RIS_TX,
    RIS_RX
  } ris_phase_t;
endpackage

// ===== verilog/ris_status.sv
`timescale 1ns/1ps
`default_nettype none
`include "ris_map.svh"

// Overview of operation
// - Flags clear at reset and protocol write
// - Host flag read clears flags and request
// - End of read phase clears flags
// - During transmit only tx, fifo flags change
// - During receive only tx, rx-start flags change
// - Request raised at phase completion
// - Tx flag set at start, request at end
// - Rx flag set at start-of-frame, request at end
// - Fifo flag: low on tx, masked during rx
// - Crc flag only when rx crc enabled
// - Bit 3 parity, bit 2 framing
// - Bit 1 single-subcarrier collision
// - Bit 0 no response within wait time
// - Enables reset to 0x3E
// - Ten-bit collision position across two registers
// - Position clears after read, resets zero
// - Position also reports error bit position
// - Strength valid from rx start to tx
// - Strength latches peak, reset on transmit
// - Each strength three bits, 4 dB steps
// - Main bits 2:0, aux 5:3, swap
// - Bit 6 shows oscillator stable
module ris_status
  import ris_pkg::*;
#(
  parameter int OSC_SETTLE_CYCLES = `RIS_OSC_SETTLE_CYC
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       chip_enable,
  input  wire logic       reg_read,
  input  wire logic       reg_write,
  input  wire logic [4:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       read_phase_end,
  input  wire logic       protocol_write,
  input  wire logic       no_rx_crc,
  input  wire logic       swap_inputs,
  input  wire logic       tx_start,
  input  wire logic       tx_done,
  input  wire logic       rx_sof,
  input  wire logic       rx_done,
  input  wire logic       fifo_level_event,
  input  wire logic       crc_fail,
  input  wire logic       parity_fail,
  input  wire logic       framing_fail,
  input  wire logic       collision_seen,
  input  wire logic       no_response,
  input  wire logic [9:0] error_position,
  input  wire logic [2:0] main_rx_input,
  input  wire logic [2:0] aux_rx_input,
  output logic [7:0]      reg_rdata,
  output logic            irq,
  output logic            rx_decoder_enable
);

  // ==========================================================
  // State
  ris_phase_t phase;
  logic [7:0] flags;
  logic [5:0] enables;
  logic [9:0] col_pos;
  logic [2:0] main_strength;
  logic [2:0] aux_strength;
  logic       osc_ok;
  logic [$clog2(OSC_SETTLE_CYCLES+1)-1:0] osc_cnt;

  // ==========================================================
  // Decode
  wire logic clr_all   = !chip_enable || protocol_write;
  wire logic rd_flags  = reg_read && reg_addr == `RIS_ADDR_FLAGS;
  wire logic rd_col    = reg_read && (reg_addr == `RIS_ADDR_ENABLES ||
                                      reg_addr == `RIS_ADDR_COL_LOW);
  wire logic wr_en     = reg_write && reg_addr == `RIS_ADDR_ENABLES;
  wire logic in_tx     = phase == RIS_TX;
  wire logic in_rx     = phase == RIS_RX;
  wire logic idle      = phase == RIS_IDLE;
  wire logic crc_ev    = crc_fail && !no_rx_crc;
  wire logic err_ev    = crc_ev || parity_fail || framing_fail;

  // Events that may set flags given the phase
  wire logic [7:0] set_ev;
  assign set_ev[`RIS_BIT_TX]        = tx_start;
  assign set_ev[`RIS_BIT_RX_START]  = rx_sof && !in_tx;
  assign set_ev[`RIS_BIT_FIFO]      = fifo_level_event && !in_rx;
  assign set_ev[`RIS_BIT_CRC]       = crc_ev && idle;
  assign set_ev[`RIS_BIT_PARITY]    = parity_fail && idle;
  assign set_ev[`RIS_BIT_FRAMING]   = framing_fail && idle;
  assign set_ev[`RIS_BIT_COLLISION] = collision_seen && idle;
  assign set_ev[`RIS_BIT_NO_RESP]   = no_response && idle;

  // Enable-gated sources that request at once
  wire logic [5:0] gated = set_ev[5:0] & enables;
  wire logic phase_end = (in_tx && tx_done) || (in_rx && rx_done);
  wire logic flag_clear = clr_all || rd_flags || read_phase_end;

  // Set wins over a clear in the same cycle
  wire logic [7:0] next_flags =
    (flag_clear ? `RIS_FLAGS_RESET : flags) | set_ev;
  wire logic next_irq =
    (irq && !flag_clear) || phase_end || (|gated);

  // ==========================================================
  // Phase tracking
  always_ff @(posedge clk) begin
    if (!reset_n || !chip_enable) begin
      phase <= RIS_IDLE;
    end else begin
      unique case (phase)
        RIS_IDLE: begin
          if (tx_start) begin
            phase <= RIS_TX;
          end else if (rx_sof) begin
            phase <= RIS_RX;
          end
        end
        RIS_TX: begin
          if (tx_done) begin
            phase <= RIS_IDLE;
          end
        end
        RIS_RX: begin
          if (rx_done) begin
            phase <= RIS_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Flags and request
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      flags <= `RIS_FLAGS_RESET;
      irq   <= 1'b0;
    end else begin
      flags <= next_flags;
      irq   <= next_irq;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rx_decoder_enable <= 1'b1;
    end else begin
      rx_decoder_enable <= !(tx_start || (in_tx && !tx_done));
    end
  end

  // ==========================================================
  // Enables and collision position
  always_ff @(posedge clk) begin
    if (!reset_n || !chip_enable) begin
      enables <= `RIS_ENABLES_RESET;
    end else if (wr_en) begin
      enables <= reg_wdata[5:0];
    end
  end

  // Capture beats read-clear so a fresh error is kept
  wire logic pos_capture = (collision_seen || err_ev) && idle;
  always_ff @(posedge clk) begin
    if (!reset_n || !chip_enable) begin
      col_pos <= `RIS_COL_RESET;
    end else if (pos_capture) begin
      col_pos <= error_position;
    end else if (rd_col) begin
      col_pos <= `RIS_COL_RESET;
    end
  end

  // ==========================================================
  // Signal strength, peak hold
  wire logic [2:0] main_sel = swap_inputs ? aux_rx_input : main_rx_input;
  wire logic [2:0] aux_sel  = swap_inputs ? main_rx_input : aux_rx_input;

  always_ff @(posedge clk) begin
    if (!reset_n || tx_start) begin
      main_strength <= `RIS_STRENGTH_RESET;
      aux_strength  <= `RIS_STRENGTH_RESET;
    end else if (!in_tx) begin
      if (main_sel > main_strength) begin
        main_strength <= main_sel;
      end
      if (aux_sel > aux_strength) begin
        aux_strength <= aux_sel;
      end
    end
  end

  // ==========================================================
  // Oscillator settle
  always_ff @(posedge clk) begin
    if (!reset_n || !chip_enable) begin
      osc_cnt <= '0;
      osc_ok  <= 1'b0;
    end else if (!osc_ok) begin
      if (osc_cnt == OSC_SETTLE_CYCLES[$bits(osc_cnt)-1:0] - 1'b1) begin
        osc_ok <= 1'b1;
      end
      osc_cnt <= osc_cnt + 1'b1;
    end
  end

  // ==========================================================
  // Read data
  wire logic [7:0] rd_mux =
    (reg_addr == `RIS_ADDR_FLAGS)    ? flags :
    (reg_addr == `RIS_ADDR_ENABLES)  ? {col_pos[9:8], enables} :
    (reg_addr == `RIS_ADDR_COL_LOW)  ? col_pos[7:0] :
    (reg_addr == `RIS_ADDR_STRENGTH) ?
      {1'b0, osc_ok, aux_strength, main_strength} : 8'h00;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      reg_rdata <= rd_mux;
    end
  end

endmodule
`default_nettype wire

// ===== test/ris_status_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Status checks
module ris_status_sva (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       chip_enable,
  input wire logic       reg_read,
  input wire logic [4:0] reg_addr,
  input wire logic       read_phase_end,
  input wire logic       protocol_write,
  input wire logic       tx_start,
  input wire logic       tx_done,
  input wire logic       rx_done,
  input wire logic       fifo_level_event,
  input wire logic       crc_fail,
  input wire logic       parity_fail,
  input wire logic       framing_fail,
  input wire logic       collision_seen,
  input wire logic       no_response,
  input wire logic [7:0] reg_rdata,
  input wire logic       irq,
  input wire logic       rx_decoder_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // A set at the clearing edge wins, so only quiet edges are judged
  wire ev = tx_done | rx_done | fifo_level_event | crc_fail | parity_fail
    | framing_fail | collision_seen | no_response;
  wire cl = read_phase_end | protocol_write | !chip_enable;
  sequence tx_then(a);
    tx_start && !cl ##1 reg_read && reg_addr == a && !cl;
  endsequence
  dec_off_a: assert property (tx_start && chip_enable |=> !rx_decoder_enable)
    else $error("decoder on in tx");
  dec_on_a: assert property (tx_done && !tx_start |=> rx_decoder_enable)
    else $error("decoder off after tx");
  // A tx_done only ends a phase while the decoder is held off for transmit
  end_irq_a: assert property (((tx_done && !rx_decoder_enable) || rx_done)
    && chip_enable |=> irq)
    else $error("no irq at phase end");
  ack_clr_a: assert property (reg_read && reg_addr == 5'h0C && !ev |=> !irq)
    else $error("irq kept after read");
  auto_clr_a: assert property ((read_phase_end || protocol_write) && !ev
    |=> !irq) else $error("irq kept after clear");
  off_clr_a: assert property (!chip_enable && !ev |=> !irq)
    else $error("irq with chip off");
  tx_flag_a: assert property (tx_then(5'h0C) |=> reg_rdata[7])
    else $error("tx flag missing");
  str_rst_a: assert property (tx_then(5'h0F) |=> reg_rdata[5:0] == 6'h00)
    else $error("strength kept in tx");
endmodule
bind ris_status ris_status_sva ris_status_sva_i (.*);
`default_nettype wire

// ===== test/ris_host.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Host side of the register port
module ris_host (
  input  wire logic       clk,
  input  wire logic       rd_go,
  input  wire logic       wr_go,
  input  wire logic [4:0] adr,
  output logic            reg_read = 1'b0,
  output logic            reg_write = 1'b0,
  output logic [4:0]      reg_addr = 5'h00
);
  // Idle address keeps toggling so a stale decode shows
  always @(posedge clk) begin
    reg_read <= rd_go;
    reg_write <= wr_go;
    reg_addr <= (rd_go || wr_go) ? adr : ~reg_addr;
  end
endmodule
`default_nettype wire

// ===== test/ris_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Status block bench
module ris_status_tb;
  logic        clk = 0, reset_n = 0, chip_enable = 1, no_rx_crc = 0;
  logic        swap_inputs = 0, rd_go = 0, wr_go = 0;
  logic [4:0]  adr = 0;
  logic [7:0]  reg_wdata = 0;
  logic [9:0]  error_position = 0;
  logic [2:0]  main_rx_input = 0, aux_rx_input = 0;
  logic [11:0] ev = 0;
  logic [31:0] s = 69842;
  int          n_fail = 0, checks_done = 0;
  wire         reg_read, reg_write, read_phase_end, protocol_write, tx_start;
  wire         tx_done, rx_sof, rx_done, fifo_level_event, crc_fail, irq;
  wire         parity_fail, framing_fail, collision_seen, no_response;
  wire         rx_decoder_enable;
  wire [4:0]   reg_addr;
  wire [7:0]   reg_rdata;
  assign {protocol_write, read_phase_end, tx_start, tx_done, rx_sof, rx_done,
    fifo_level_event, crc_fail, parity_fail, framing_fail, collision_seen,
    no_response} = ev;
  ris_status #(.OSC_SETTLE_CYCLES(8)) ris_status_i (.*);
  ris_host ris_host_i (.*);
  initial forever #10 clk = ~clk;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  function automatic logic [7:0] sx(input logic [31:0] v);
    return {2'b01, v[16] ? v[12:10] : v[15:13], v[16] ? v[15:13] : v[12:10]};
  endfunction
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    rd_go <= 1;
    adr <= a;
    @(posedge clk);
    rd_go <= 0;
    ev <= 0;
    repeat (2) @(posedge clk);
    cmp("reg_rdata", e, reg_rdata);
  endtask
  task automatic pe(input int i);
    ev <= 12'h001 << i;
    @(posedge clk);
    ev <= 0;
    @(posedge clk);
  endtask
  task automatic report_and_stop;
    if (n_fail == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1;
    @(posedge clk);
    rd(5'h0D, 8'h3E);
    rd(5'h0C, 8'h00);
    rd(5'h0E, 8'h00);
    for (int i = 0; i < 6; i++) begin
      pe(i);
      cmp("irq", 8'(i != 0), {7'h0, irq});
      rd(5'h0C, 8'h01 << i);
    end
    no_rx_crc <= 1;
    pe(4);
    rd(5'h0C, 8'h00);
    no_rx_crc <= 0;
    wr_go <= 1;
    adr <= 5'h0D;
    reg_wdata <= 8'hC1;
    @(posedge clk);
    wr_go <= 0;
    @(posedge clk);
    pe(0);
    cmp("irq", 8'h01, {7'h0, irq});
    chip_enable <= 0;
    @(posedge clk);
    chip_enable <= 1;
    @(posedge clk);
    rd(5'h0D, 8'h3E);
    ev <= 12'h200;
    rd(5'h0C, 8'h80);
    pe(8);
    pe(11);
    cmp("irq", 8'h00, {7'h0, irq});
    for (int k = 0; k < 4; k++) begin
      s = xs(s);
      error_position <= s[9:0];
      main_rx_input <= s[12:10];
      aux_rx_input <= s[15:13];
      swap_inputs <= s[16];
      pe(1);
      rd(s[17] ? 5'h0E : 5'h0D, s[17] ? s[7:0] : {s[9:8], 6'h3E});
      rd(s[17] ? 5'h0D : 5'h0E, s[17] ? 8'h3E : 8'h00);
      rd(5'h0C, 8'h02);
      ev <= 12'h200;
      rd(5'h0F, 8'h40);
      cmp("irq", 8'h00, {7'h0, irq});
      pe(8);
      cmp("irq", 8'h01, {7'h0, irq});
      rd(5'h0C, 8'h80);
      pe(7);
      cmp("irq", 8'h00, {7'h0, irq});
      pe(6);
      rd(5'h0C, 8'h40);
      rd(5'h0F, sx(s));
    end
    pe(5);
    pe(10);
    rd(5'h0C, 8'h00);
    report_and_stop;
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    report_and_stop;
  end
endmodule
`default_nettype wire
